// File: hw/temp_readout_map.vh
`ifndef TEMP_READOUT_MAP_VH
`define TEMP_READOUT_MAP_VH

// configuration register 1 (plain input byte), range-select bit position
`define CFG1_RANGE_BIT 2

// high-byte coding
`define STD_HI_MIN 8'h00
`define STD_HI_MAX 8'h7f
`define EXT_OFFSET 10'h040
`define EXT_HI_MIN 8'h00
`define EXT_HI_MAX 8'hff

// low byte: fraction in sixteenths in the upper nibble
`define FRAC_LSB 4
`define FRAC_BITS 4

// read-port selector values
`define SEL_LOCAL_HI 3'h0
`define SEL_LOCAL_LO 3'h1
`define SEL_REMOTE_HI 3'h2
`define SEL_REMOTE_LO 3'h3
`define SEL_STATUS 3'h4
`define SEL_FORMAT 3'h5

// status byte bit positions
`define ST_LOCAL_HIGH 0
`define ST_LOCAL_LOW 1
`define ST_REMOTE_HIGH 2
`define ST_REMOTE_LOW 3
`define ST_LOCAL_CRIT 5
`define ST_REMOTE_CRIT 4
`define ST_LINE_LOW 6

// format byte bit positions
`define FMT_LOCAL_EXT 0
`define FMT_REMOTE_EXT 1

// reset values
`define RESULT_RST 8'h00
`define RDATA_RST 8'h00
`define ALARM_RST 1'b0
`define EXT_FLAG_RST 1'b0

`endif

// File: hw/temp_format.v
`timescale 1ns/1ps
`default_nettype none
`include "temp_readout_map.vh"

module temp_format #(
    parameter TW = 13
) (
    input wire signed [TW-1:0] temp_i,
    input wire ext_i,
    output reg [7:0] hi_o,
    output reg [7:0] lo_o
);

    reg signed [TW-5:0] whole;
    reg signed [TW-3:0] shifted;

    always @* begin
        whole = temp_i[TW-1:`FRAC_LSB];
        shifted = {{2{whole[TW-5]}}, whole} + $signed(`EXT_OFFSET);
        // fraction in upper nibble, lower nibble always zero
        lo_o = {temp_i[`FRAC_BITS-1:0], 4'h0}; // R10 R11 R16
        if (ext_i) begin
            // unsigned code, zero means minus 64 degrees
            if (shifted < 0) begin // R17
                hi_o = `EXT_HI_MIN;
                lo_o = 8'h00;
            end else if (shifted > $signed({2'b00, `EXT_HI_MAX})) begin // R7
                hi_o = `EXT_HI_MAX;
                lo_o = 8'h00;
            end else begin
                hi_o = shifted[7:0]; // R6 R9
            end
        end else begin
            if (whole < 0) begin
                hi_o = `STD_HI_MIN; // R2
                lo_o = 8'h00;
            end else if (whole > $signed({1'b0, `STD_HI_MAX})) begin
                hi_o = `STD_HI_MAX; // R3
                lo_o = 8'h00;
            end else begin
                hi_o = whole[7:0]; // R1 R9
            end
        end
    end

endmodule // temp_format

`default_nettype wire

// File: hw/temp_readout.v
// Behaviour
// R1: default format reports 0 to 127 degrees, plain binary, one count per degree.
// R2: default format clamps results below zero to high byte 00.
// R3: default format saturates results above 127 to high byte 7f.
// R4: configuration 1 bit 2 selects extended range; clear selects default range.
// R5: range change applies from next conversion; stored results keep old format.
// R6: extended format adds 64 to the binary value.
// R7: extended format spans minus 64 (code 0) to 191 (code ff).
// R8: each channel result is held as a high and low byte pair.
// R9: high byte holds whole degrees, one degree per count.
// R10: low byte holds the fractional part of the temperature.
// R11: resolution fixed at one sixteenth degree on both channels.
// R12: early alarm when a result is above high or below low limit.
// R13: critical alarm when a result exceeds its critical limit.
// R14: alarm pins only pull low or release, for wired-OR sharing.
// R15: host reaches results and status through the serial target.
// R16: low byte upper nibble is sixteenths, lower nibble always zero.
// R17: extended high byte is unsigned, zero meaning minus 64 degrees.
// R18: both bytes of a channel update together from one conversion.
`timescale 1ns/1ps
`default_nettype none
`include "temp_readout_map.vh"

module temp_readout #(
    parameter TW = 13
) (
    input wire ref_clk_i,
    input wire rstn_i,
    input wire clk_en_i,
    input wire conv_done_i,
    input wire conv_remote_i,
    input wire signed [TW-1:0] conv_temp_i,
    input wire [7:0] cfg1_i,
    input wire [7:0] local_high_lim_i,
    input wire [7:0] local_low_lim_i,
    input wire [7:0] remote_high_lim_i,
    input wire [7:0] remote_low_lim_i,
    input wire [7:0] local_crit_lim_i,
    input wire [7:0] remote_crit_lim_i,
    input wire [2:0] rd_sel_i,
    input wire early_alarm_n_i,
    output reg early_alarm_n_o,
    output reg early_alarm_n_oe_o,
    input wire critical_limit_alarm_n_i,
    output reg critical_limit_alarm_n_o,
    output reg critical_limit_alarm_n_oe_o,
    output reg [7:0] rd_data_o
);

    ////////////////////////////////////////////////////////////////////////////
    // compare helpers, shared by both channels and every limit

    // strict compares: a result sitting exactly on a limit stays quiet
    function above_limit(input [7:0] value, input [7:0] limit);
        above_limit = value > limit;
    endfunction

    function below_limit(input [7:0] value, input [7:0] limit);
        below_limit = value < limit;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // formatting of the incoming conversion

    wire [7:0] fmt_hi;
    wire [7:0] fmt_lo;
    // range bit is sampled only with the conversion strobe
    wire conv_ext = cfg1_i[`CFG1_RANGE_BIT]; // R4

    temp_format #(
        .TW(TW)
    ) u_fmt (
        .temp_i(conv_temp_i),
        .ext_i(conv_ext),
        .hi_o(fmt_hi),
        .lo_o(fmt_lo)
    );

    ////////////////////////////////////////////////////////////////////////////
    // result byte pairs

    reg [7:0] local_hi_q;
    reg [7:0] local_lo_q;
    reg [7:0] remote_hi_q;
    reg [7:0] remote_lo_q;
    reg local_ext_q;
    reg remote_ext_q;

    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            local_hi_q <= `RESULT_RST;
            local_lo_q <= `RESULT_RST;
            remote_hi_q <= `RESULT_RST;
            remote_lo_q <= `RESULT_RST;
            local_ext_q <= `EXT_FLAG_RST;
            remote_ext_q <= `EXT_FLAG_RST;
        end else if (clk_en_i && conv_done_i) begin
            // both halves written in the same cycle, so a read never mixes conversions
            if (conv_remote_i) begin
                remote_hi_q <= fmt_hi; // R8 R18
                remote_lo_q <= fmt_lo; // R8 R18
                remote_ext_q <= conv_ext; // R5
            end else begin
                local_hi_q <= fmt_hi; // R8 R18
                local_lo_q <= fmt_lo; // R8 R18
                local_ext_q <= conv_ext; // R5
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // limit compare on the stored high bytes
    // limits are expected in the same coding as the results; a range change
    // leaves the stored byte in its old coding until the next conversion

    wire local_above = above_limit(local_hi_q, local_high_lim_i); // R12
    wire local_below = below_limit(local_hi_q, local_low_lim_i); // R12
    wire remote_above = above_limit(remote_hi_q, remote_high_lim_i); // R12
    wire remote_below = below_limit(remote_hi_q, remote_low_lim_i); // R12
    wire local_crit = above_limit(local_hi_q, local_crit_lim_i); // R13
    wire remote_crit = above_limit(remote_hi_q, remote_crit_lim_i); // R13
    wire early_any = local_above | local_below | remote_above | remote_below;
    wire crit_any = local_crit | remote_crit;

    reg line_low_q;

    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            early_alarm_n_o <= `ALARM_RST;
            early_alarm_n_oe_o <= `ALARM_RST;
            critical_limit_alarm_n_o <= `ALARM_RST;
            critical_limit_alarm_n_oe_o <= `ALARM_RST;
            line_low_q <= `ALARM_RST;
        end else if (clk_en_i) begin
            // open drain: data held low, only the enable moves
            early_alarm_n_o <= 1'b0; // R14
            critical_limit_alarm_n_o <= 1'b0; // R14
            early_alarm_n_oe_o <= early_any; // R12 R14
            critical_limit_alarm_n_oe_o <= crit_any; // R13 R14
            // another device on the shared line may hold it low
            line_low_q <= ~(early_alarm_n_i & critical_limit_alarm_n_i);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port toward the serial target

    reg [7:0] status;
    reg [7:0] fmt_flags;

    always @* begin
        status = 8'h00;
        status[`ST_LOCAL_HIGH] = local_above; // R12
        status[`ST_LOCAL_LOW] = local_below; // R12
        status[`ST_REMOTE_HIGH] = remote_above; // R12
        status[`ST_REMOTE_LOW] = remote_below; // R12
        status[`ST_LOCAL_CRIT] = local_crit; // R13
        status[`ST_REMOTE_CRIT] = remote_crit; // R13
        status[`ST_LINE_LOW] = line_low_q; // R14
    end

    // lets the host tell which coding each stored result was taken in
    always @* begin
        fmt_flags = 8'h00;
        fmt_flags[`FMT_LOCAL_EXT] = local_ext_q; // R5
        fmt_flags[`FMT_REMOTE_EXT] = remote_ext_q; // R5
    end

    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_data_o <= `RDATA_RST;
        end else if (clk_en_i) begin
            case (rd_sel_i) // R15
                `SEL_LOCAL_HI: rd_data_o <= local_hi_q;
                `SEL_LOCAL_LO: rd_data_o <= local_lo_q;
                `SEL_REMOTE_HI: rd_data_o <= remote_hi_q;
                `SEL_REMOTE_LO: rd_data_o <= remote_lo_q;
                `SEL_STATUS: rd_data_o <= status;
                `SEL_FORMAT: rd_data_o <= fmt_flags;
                default: rd_data_o <= 8'h00;
            endcase
        end
    end

endmodule // temp_readout

`default_nettype wire

// File: tb/temp_readout_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module temp_readout_checker #(parameter TW = 13) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic conv_done_i,
    input wire logic conv_remote_i,
    input wire logic signed [TW-1:0] conv_temp_i,
    input wire logic [7:0] cfg1_i,
    input wire logic [2:0] rd_sel_i,
    input wire logic early_alarm_n_o,
    input wire logic critical_limit_alarm_n_o,
    input wire logic [7:0] rd_data_o
);
default clocking @(posedge ref_clk_i); endclocking
default disable iff (!rstn_i);
////////////////////////////////////////////////////////////////
// local conversion, then a read of that channel with nothing landing between
sequence conv_rd(bit x, bit c, bit [2:0] s);
    clk_en_i && conv_done_i && !conv_remote_i && cfg1_i[2] == x && c
    ##1 clk_en_i && !conv_done_i && rd_sel_i == s;
endsequence
chk_std_whole: assert property (conv_rd(0, conv_temp_i >= 0 && conv_temp_i < 2048, 3'h0)
    |=> rd_data_o == $past(conv_temp_i[11:4], 2)) else $error("whole degrees off");
chk_std_clamp: assert property (conv_rd(0, conv_temp_i < 0, 3'h0)
    |=> rd_data_o == 8'h00) else $error("negative not clamped");
chk_std_saturate: assert property (conv_rd(0, conv_temp_i > 2047, 3'h0)
    |=> rd_data_o == 8'h7f) else $error("no saturation");
chk_ext_floor: assert property (conv_rd(1, conv_temp_i < -1024, 3'h0)
    |=> rd_data_o == 8'h00) else $error("extended floor off");
chk_ext_ceiling: assert property (conv_rd(1, conv_temp_i > 3071, 3'h0)
    |=> rd_data_o == 8'hff) else $error("extended ceiling off");
chk_format_flag: assert property (conv_rd(1, 1'b1, 3'h5)
    |=> rd_data_o[0] == 1'b1) else $error("format flag missing");
chk_frac_nibble: assert property (clk_en_i && rd_sel_i inside {3'h1, 3'h3}
    |=> rd_data_o[3:0] == 4'h0) else $error("low nibble not zero");
chk_unmapped_sel: assert property (clk_en_i && rd_sel_i > 3'h5
    |=> rd_data_o == 8'h00) else $error("unmapped read not zero");
// the pins may only pull low, never drive high
chk_pins_low_only: assert property (!early_alarm_n_o && !critical_limit_alarm_n_o)
    else $error("alarm pin driven high");
endmodule // temp_readout_checker
bind temp_readout temp_readout_checker #(.TW(TW)) chk (.*);
`default_nettype wire

// File: tb/host_reader.sv
`timescale 1ns/1ps
`default_nettype none
module host_reader (
    input wire logic ref_clk_i,
    input wire logic [7:0] rd_data_i,
    output logic [2:0] rd_sel_o
);
// parks on an unmapped select so a stale byte never looks valid
initial rd_sel_o = 3'h7;
// called at a falling edge; select held over the answer edge
task automatic read(input logic [2:0] s, output logic [7:0] d);
    rd_sel_o = s;
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    d = rd_data_i;
    // park a full cycle so a following read never sets the select twice in one step
    rd_sel_o = 3'h7;
    @(negedge ref_clk_i);
endtask
endmodule // host_reader
`default_nettype wire

// File: tb/tb_temp_readout.sv
`timescale 1ns/1ps
`default_nettype none
module tb_temp_readout;
logic clk = 0, rstn = 0, en = 1, done = 0, rem = 0, other_pull = 0;
logic signed [12:0] temp = 0;
logic [7:0] cfg = 0, hl = 8'hff, ll = 8'h00, cl = 8'hff, d;
logic [2:0] sel;
wire early_o, early_oe, crit_o, crit_oe;
wire [7:0] rdata;
// pulled-up shared lines; other_pull stands for a second device on the early line
wire early_ln = (early_oe ? early_o : 1'b1) & ~other_pull;
wire crit_ln = crit_oe ? crit_o : 1'b1;
int miscompares = 0, comparisons = 0;
typedef struct {logic x; logic signed [12:0] t; logic [7:0] h, l;} row_t;
row_t rows[10] = '{'{0, 13'h198, 8'h19, 8'h80}, '{0, -13'sh10, 8'h00, 8'h00},
    '{0, 13'hc80, 8'h7f, 8'h00}, '{0, 13'h7ff, 8'h7f, 8'hf0}, '{0, 13'h001, 8'h00, 8'h10},
    '{1, -13'sh400, 8'h00, 8'h00}, '{1, -13'sh410, 8'h00, 8'h00},
    '{1, 13'h000, 8'h40, 8'h00}, '{1, 13'hbff, 8'hff, 8'hf0}, '{1, 13'hc80, 8'hff, 8'h00}};
temp_readout #(.TW(13)) uut (.ref_clk_i(clk), .rstn_i(rstn), .clk_en_i(en), .conv_done_i(done),
    .conv_remote_i(rem), .conv_temp_i(temp), .cfg1_i(cfg), .local_high_lim_i(hl),
    .local_low_lim_i(ll), .remote_high_lim_i(hl), .remote_low_lim_i(ll),
    .local_crit_lim_i(cl), .remote_crit_lim_i(cl), .rd_sel_i(sel),
    .early_alarm_n_i(early_ln), .early_alarm_n_o(early_o), .early_alarm_n_oe_o(early_oe),
    .critical_limit_alarm_n_i(crit_ln), .critical_limit_alarm_n_o(crit_o),
    .critical_limit_alarm_n_oe_o(crit_oe), .rd_data_o(rdata));
host_reader host (.ref_clk_i(clk), .rd_data_i(rdata), .rd_sel_o(sel));
////////////////////////////////////////////////////////////////
initial forever #12.5 clk = ~clk;
task chk(string n, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
        $display("wrong value %s expected %h seen %h", n, e, g);
        miscompares++;
    end
endtask
task conv(logic r, logic x, logic signed [12:0] t);
    rem = r;
    cfg = x ? 8'h04 : 8'h00;
    temp = t;
    done = 1;
    @(negedge clk) done = 0;
endtask
task rd(string n, logic [2:0] s, logic [7:0] e);
    host.read(s, d);
    chk(n, e, d);
endtask
task close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
////////////////////////////////////////////////////////////////
initial begin
    #100000;
    miscompares++;
    close_out;
end
initial begin
    repeat (3) @(negedge clk);
    rstn = 1;
    foreach (rows[i]) begin
        conv(i % 3 == 2, rows[i].x, rows[i].t);
        rd("hi", (i % 3 == 2) ? 3'h2 : 3'h0, rows[i].h);
        rd("lo", (i % 3 == 2) ? 3'h3 : 3'h1, rows[i].l);
    end
    $display("test table done");
    conv(0, 0, 13'hc80);
    rd("sat hi", 3'h0, 8'h7f);
    rd("sat lo", 3'h1, 8'h00);
    conv(0, 1, 13'h198);
    rd("format", 3'h5, 8'h03);
    cfg = 8'h00;
    rd("kept", 3'h0, 8'h59);
    conv(1, 0, 13'h198);
    rd("format2", 3'h5, 8'h01);
    en = 0;
    conv(0, 0, 13'h7ff);
    en = 1;
    rd("frozen", 3'h0, 8'h59);
    $display("test range done");
    hl = 8'h58;
    cl = 8'h58;
    repeat (4) @(negedge clk);
    chk("early", 8'h01, {7'h0, early_oe});
    chk("crit", 8'h01, {7'h0, crit_oe});
    rd("status", 3'h4, 8'h61);
    {hl, cl, ll} = 24'hffff60;
    repeat (4) @(negedge clk);
    chk("crit off", 8'h00, {7'h0, crit_oe});
    rd("status2", 3'h4, 8'h4a);
    {hl, cl, ll} = 24'h101000;
    repeat (4) @(negedge clk);
    chk("crit both", 8'h01, {7'h0, crit_oe});
    rd("status3", 3'h4, 8'h75);
    {hl, cl, ll} = 24'hffff00;
    other_pull = 1;
    repeat (4) @(negedge clk);
    chk("early quiet", 8'h00, {7'h0, early_oe});
    rd("shared", 3'h4, 8'h40);
    other_pull = 0;
    $display("test alarm done");
    rstn = 0;
    @(negedge clk);
    chk("rst data", 8'h00, rdata);
    chk("rst oe", 8'h00, {6'h0, early_oe, crit_oe});
    rstn = 1;
    rd("rst hi", 3'h0, 8'h00);
    $display("test reset done");
    close_out;
end
endmodule // tb_temp_readout
`default_nettype wire
